//--- hspc_defs.vh
`ifndef HSPC_DEFS_VH
`define HSPC_DEFS_VH
// Register byte addresses
`define HSPC_ADDR_CTRL 12'h000
`define HSPC_ADDR_EDGE 12'h004
`define HSPC_ADDR_DIR 12'h008
`define HSPC_ADDR_QMODE 12'h00c
`define HSPC_ADDR_RSTDIS 12'h010
`define HSPC_ADDR_IRQEN 12'h014
`define HSPC_ADDR_RESET 12'h018
`define HSPC_ADDR_STATUS 12'h01c
`define HSPC_ADDR_CAP_LO 12'h020
`define HSPC_ADDR_CAP_HI 12'h024
`define HSPC_ADDR_PRESET_BASE 12'h040
`define HSPC_ADDR_COUNT_BASE 12'h080
`define HSPC_ADDR_BIND 12'h0c0
// Quadrature mode codes
`define HSPC_QMODE_DOUBLE 2'h2
`define HSPC_QMODE_QUAD 2'h3
`define HSPC_QMODE_RESET 2'h3
// Counter indices: 0..7 scan counters, 8 single-input hw, 9 up/down, 10 quadrature
`define HSPC_HW_SINGLE 4
`define HSPC_CH_SINGLE 8
`define HSPC_CH_UPDN 9
`define HSPC_CH_QUAD 10
// Rate limits in Hz, clock in Hz
`define HSPC_CLK_HZ 25000000
`define HSPC_SCAN_MAX_HZ 10000
`define HSPC_QUAD_LO_HZ 15000
`define HSPC_QUAD_HI_HZ 5000
`define HSPC_HW_FAST_HZ 100000
`define HSPC_HW_SLOW_HZ 20000
`endif

//--- hspc_counters.v
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "hspc_defs.vh"
module hspc_counters #(
    parameter NSCAN = 8,
    parameter FAST_MODEL = 1
) (
    input wire sys_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] count_in,
    output reg [10:0] counter_output,
    output wire syntax_error,
    output reg reset_input_interrupt
);
    localparam NCH = NSCAN + 3;
    // Minimum pulse spacing in cycles for each rate ceiling
    localparam SCAN_GAP = `HSPC_CLK_HZ / `HSPC_SCAN_MAX_HZ;
    localparam QLO_GAP = `HSPC_CLK_HZ / `HSPC_QUAD_LO_HZ;
    localparam QHI_GAP = `HSPC_CLK_HZ / `HSPC_QUAD_HI_HZ;
    localparam HW_GAP = FAST_MODEL ? `HSPC_CLK_HZ / `HSPC_HW_FAST_HZ
                                   : `HSPC_CLK_HZ / `HSPC_HW_SLOW_HZ;

    reg [NCH-1:0] ctrl;
    reg [7:0] edge_sel;
    reg [7:0] dir_sel;
    reg [1:0] quadrature_mode_reg;
    reg reset_disable_bit_a;
    reg irq_en;
    reg syntax_flag;
    reg [31:0] capture_low_word;
    reg [31:0] capture_high_word;
    reg [31:0] bind_map;
    reg [31:0] preset_count [0:NCH-1];
    reg [31:0] present_count [0:NCH-1];
    reg [7:0] sync1;
    reg [7:0] sync2;
    reg [7:0] prev;
    reg [NCH-1:0] reset_cmd;
    reg [NCH-1:0] load_cmd;
    reg [31:0] load_val;

    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    wire known = (paddr <= `HSPC_ADDR_CAP_HI) || (paddr == `HSPC_ADDR_BIND) ||
                 ((paddr >= `HSPC_ADDR_PRESET_BASE) &&
                  (paddr < `HSPC_ADDR_PRESET_BASE + 4 * NCH)) ||
                 ((paddr >= `HSPC_ADDR_COUNT_BASE) &&
                  (paddr < `HSPC_ADDR_COUNT_BASE + 4 * NCH));
    assign pslverr = psel & penable & ~known;
    assign syntax_error = syntax_flag;

    // Two-flop synchroniser then edge detect on the second stage
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            prev <= 8'h00;
        end else begin
            sync1 <= count_in;
            sync2 <= sync1;
            prev <= sync2;
        end
    end
    wire [7:0] rise = sync2 & ~prev;
    wire [7:0] fall = ~sync2 & prev;

    // Input ownership: overlapping enables on one input is an error
    wire single_on = ctrl[`HSPC_CH_SINGLE];
    wire updn_on = ctrl[`HSPC_CH_UPDN];
    wire quad_on = ctrl[`HSPC_CH_QUAD];
    wire [7:0] own_hw = ({6'h00, {2{single_on}}}) | ({6'h00, {2{updn_on}}}) |
                        ({4'h0, {2{quad_on}}, 2'h0});
    wire conflict_hw = (single_on & updn_on);
    wire [7:0] scan_on = ctrl[7:0];
    wire conflict_scan = |(scan_on & own_hw);
    // Conflicting binding rejected on every cycle the enables hold it, one edge after the enabling write lands
    wire bind_bad = conflict_hw | conflict_scan;

    // Per-channel rate guard: edges closer than the ceiling are dropped
    reg [15:0] gap_cnt [0:NCH-1];
    wire [NCH-1:0] step;
    wire [NCH-1:0] down;
    wire [NCH-1:0] ready_ch;
    genvar g;
    generate
        for (g = 0; g < NSCAN; g = g + 1) begin : g_scan
            // Edge choice and direction per scan counter
            assign step[g] = scan_on[g] & ready_ch[g] &
                             (edge_sel[g] ? fall[g] : rise[g]);
            assign down[g] = dir_sel[g];
        end
    endgenerate

    // Hardware single input on input 0, companion reset on input 1
    assign step[`HSPC_CH_SINGLE] = single_on & ready_ch[`HSPC_CH_SINGLE] & rise[0];
    assign down[`HSPC_CH_SINGLE] = 1'b0;
    // Up/down two-input: input 0 up, input 1 down
    wire ud_up = rise[0];
    wire ud_dn = rise[1];
    // Direction-input form on the same pair: input 0 counts, input 1 level sets sense
    wire dir_mode = bind_map[0];
    wire dir_down = sync2[1];
    wire ud_step = dir_mode ? rise[0] : (ud_up ^ ud_dn);
    assign step[`HSPC_CH_UPDN] = updn_on & ready_ch[`HSPC_CH_UPDN] & ud_step;
    assign down[`HSPC_CH_UPDN] = dir_mode ? dir_down : ud_dn;

    // Quadrature on inputs 2 (A) and 3 (B)
    wire qa = sync2[2];
    wire qb = sync2[3];
    wire qa_ev = rise[2] | fall[2];
    wire qb_ev = rise[3] | fall[3];
    // Double rate counts A edges only, quadruple counts both phases
    wire q_ev = (quadrature_mode_reg == `HSPC_QMODE_DOUBLE) ? (qa_ev & ~qb_ev)
                : (qa_ev ^ qb_ev);
    // After an A edge, A differing from B means A leads
    wire q_up = qa_ev ? (qa != qb) : (qa == qb);
    assign step[`HSPC_CH_QUAD] = quad_on & ready_ch[`HSPC_CH_QUAD] & q_ev;
    assign down[`HSPC_CH_QUAD] = ~q_up;

    // Rate guard counters and per-channel spacing
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_gap
            localparam integer LIM = (g < NSCAN) ? SCAN_GAP :
                (g == `HSPC_CH_QUAD) ? QLO_GAP : HW_GAP;
            assign ready_ch[g] = (gap_cnt[g] == 16'h0000);
            always @(posedge sys_clk) begin
                if (!rst_n) begin
                    gap_cnt[g] <= 16'h0000;
                end else if (step[g]) begin
                    gap_cnt[g] <= LIM[15:0] - 16'h0001;
                end else if (gap_cnt[g] != 16'h0000) begin
                    gap_cnt[g] <= gap_cnt[g] - 16'h0001;
                end
            end
        end
    endgenerate

    // Companion reset input: rising or falling selected by edge bit 1
    wire rst_edge = edge_sel[1] ? fall[1] : rise[1];
    wire rst_active = single_on & ~reset_disable_bit_a & rst_edge;
    wire hw_irq = rst_active & irq_en;
    wire hw_plain_rst = rst_active & ~irq_en;

    // Count update, preset compare, captures
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_cnt
            wire clr = reset_cmd[g] |
                       ((g == `HSPC_CH_SINGLE) && (hw_plain_rst | hw_irq));
            wire [31:0] nv = down[g] ? present_count[g] - 32'h1
                                     : present_count[g] + 32'h1;
            always @(posedge sys_clk) begin
                if (!rst_n) begin
                    present_count[g] <= 32'h0;
                    counter_output[g] <= 1'b0;
                end else if (clr) begin
                    present_count[g] <= 32'h0;
                    counter_output[g] <= 1'b0;
                end else if (load_cmd[g]) begin
                    present_count[g] <= load_val;
                end else if (step[g]) begin
                    present_count[g] <= nv;
                    // Signed compare: on at or above preset, off below
                    counter_output[g] <= ($signed(nv) >= $signed(preset_count[g]));
                end
            end
        end
    endgenerate

    // Capture the count before the clear, then flag the interrupt routine
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            capture_low_word <= 32'h0;
            capture_high_word <= 32'h0;
            reset_input_interrupt <= 1'b0;
        end else begin
            reset_input_interrupt <= hw_irq;
            if (hw_irq) begin
                capture_low_word <= {16'h0000, present_count[`HSPC_CH_SINGLE][15:0]};
                capture_high_word <= {16'h0000, present_count[`HSPC_CH_SINGLE][31:16]};
            end
        end
    end

    // APB writes; reset and load are one-cycle commands
    integer i;
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= {NCH{1'b0}};
            edge_sel <= 8'h00;
            dir_sel <= 8'h00;
            quadrature_mode_reg <= `HSPC_QMODE_RESET;
            reset_disable_bit_a <= 1'b0;
            irq_en <= 1'b0;
            syntax_flag <= 1'b0;
            reset_cmd <= {NCH{1'b0}};
            load_cmd <= {NCH{1'b0}};
            load_val <= 32'h0;
            bind_map <= 32'h0;
            for (i = 0; i < NCH; i = i + 1) begin
                preset_count[i] <= 32'h0;
            end
        end else begin
            reset_cmd <= {NCH{1'b0}};
            load_cmd <= {NCH{1'b0}};
            if (bind_bad) begin
                // Refuse the binding: drop back to no counters
                ctrl <= {NCH{1'b0}};
                syntax_flag <= 1'b1;
            end
            if (wr) begin
                case (paddr)
                    `HSPC_ADDR_CTRL: begin
                        ctrl <= pwdata[NCH-1:0];
                    end
                    `HSPC_ADDR_EDGE: edge_sel <= pwdata[7:0];
                    `HSPC_ADDR_DIR: dir_sel <= pwdata[7:0];
                    `HSPC_ADDR_QMODE: begin
                        quadrature_mode_reg <= (pwdata[1:0] == `HSPC_QMODE_DOUBLE) ?
                            `HSPC_QMODE_DOUBLE : `HSPC_QMODE_QUAD;
                    end
                    `HSPC_ADDR_RSTDIS: reset_disable_bit_a <= pwdata[0];
                    `HSPC_ADDR_IRQEN: irq_en <= pwdata[0];
                    `HSPC_ADDR_RESET: reset_cmd <= pwdata[NCH-1:0];
                    `HSPC_ADDR_STATUS: begin
                        if (pwdata[0] && !bind_bad) begin
                            syntax_flag <= 1'b0;
                        end
                    end
                    `HSPC_ADDR_BIND: bind_map <= pwdata;
                    default: begin
                        for (i = 0; i < NCH; i = i + 1) begin
                            if (paddr == `HSPC_ADDR_PRESET_BASE + 4 * i) begin
                                preset_count[i] <= pwdata;
                            end
                            if (paddr == `HSPC_ADDR_COUNT_BASE + 4 * i) begin
                                load_cmd[i] <= 1'b1;
                                load_val <= pwdata;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // APB read mux, registered so data changes only on a read
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= 32'h0;
            case (paddr)
                `HSPC_ADDR_CTRL: prdata <= {{(32-NCH){1'b0}}, ctrl};
                `HSPC_ADDR_EDGE: prdata <= {24'h0, edge_sel};
                `HSPC_ADDR_DIR: prdata <= {24'h0, dir_sel};
                `HSPC_ADDR_QMODE: prdata <= {30'h0, quadrature_mode_reg};
                `HSPC_ADDR_RSTDIS: prdata <= {31'h0, reset_disable_bit_a};
                `HSPC_ADDR_IRQEN: prdata <= {31'h0, irq_en};
                `HSPC_ADDR_STATUS: prdata <= {31'h0, syntax_flag};
                `HSPC_ADDR_CAP_LO: prdata <= capture_low_word;
                `HSPC_ADDR_CAP_HI: prdata <= capture_high_word;
                `HSPC_ADDR_BIND: prdata <= bind_map;
                default: begin
                    for (i = 0; i < NCH; i = i + 1) begin
                        if (paddr == `HSPC_ADDR_PRESET_BASE + 4 * i) begin
                            prdata <= preset_count[i];
                        end
                        if (paddr == `HSPC_ADDR_COUNT_BASE + 4 * i) begin
                            prdata <= present_count[i];
                        end
                    end
                end
            endcase
        end
    end
    wire unused_rd = rd;
endmodule
`default_nettype wire

//--- hspc_props_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "hspc_defs.vh"
module hspc_props (
    input wire sys_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] count_in,
    input wire [10:0] counter_output,
    input wire syntax_error,
    input wire reset_input_interrupt
);
    // Completed write, shared by the register checks
    wire wr_q = psel && penable && pwrite;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Zero wait states, so a master never stalls
    zero_wait_a: assert property (psel |-> pready)
        else $error("pready low in a transfer");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    unmapped_err_a: assert property (psel && penable && paddr == 12'hffc |-> pslverr)
        else $error("unmapped access not refused");
    irq_pulse_a: assert property (reset_input_interrupt |=> !reset_input_interrupt)
        else $error("interrupt pulse too long");
    // Interrupt only follows a recent edge on the reset input
    irq_cause_a: assert property (
        reset_input_interrupt |-> $past(count_in[1], 2) != $past(count_in[1], 7))
        else $error("interrupt without reset edge");
    // Flag is registered one edge after the conflicting enables land
    conflict_flag_a: assert property (
        wr_q && paddr == `HSPC_ADDR_CTRL && pwdata[0] && pwdata[8] |=> ##1 syntax_error)
        else $error("conflict not flagged");
    syntax_sticky_a: assert property (
        syntax_error && !(wr_q && paddr == `HSPC_ADDR_STATUS && pwdata[0]) |=> syntax_error)
        else $error("syntax flag dropped");
    // Command is registered, so the clear shows two edges after the write
    cmd_clear_a: assert property (
        wr_q && paddr == `HSPC_ADDR_RESET |=> ##1
        (counter_output & $past(pwdata[10:0], 2)) == 11'h000)
        else $error("output kept after reset command");
    cover property (reset_input_interrupt);
    cover property ($rose(syntax_error));
    cover property (pslverr);
    cover property ($fell(counter_output[4]));
endmodule
bind hspc_counters hspc_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .count_in(count_in), .counter_output(counter_output),
    .syntax_error(syntax_error), .reset_input_interrupt(reset_input_interrupt));
`default_nettype wire

//--- hspc_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
module hspc_pulse_src (
    input wire logic sys_clk,
    output var logic [7:0] count_in
);
    initial count_in = 8'h00;
    // Holding each level n cycles keeps edges within the rated input rate
    task automatic step(input int b, input logic v, input int n);
        @(posedge sys_clk);
        count_in[b] <= v;
        repeat (n) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "hspc_defs.vh"
module testbench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, rdat;
    wire [31:0] prdata;
    wire pready, pslverr, syntax_error, reset_input_interrupt;
    wire [7:0] count_in;
    wire [10:0] counter_output;
    wire [11:0] flags = {syntax_error, counter_output};
    int bad_count = 0, checks = 0, irqs = 0;
    localparam int SG = 2550;
    localparam int QG = 1700;
    localparam int HG = 260;
    localparam logic [11:0] CB = `HSPC_ADDR_COUNT_BASE;

    always #20 sys_clk = ~sys_clk;

    hspc_counters DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_in(count_in), .counter_output(counter_output),
        .syntax_error(syntax_error), .reset_input_interrupt(reset_input_interrupt));
    hspc_pulse_src src (.sys_clk(sys_clk), .count_in(count_in));

    // Interrupt pulses are single cycles, so count every one
    always @(posedge sys_clk) begin
        if (reset_input_interrupt === 1'b1)
            irqs++;
    end

    function automatic logic [11:0] at(input logic [11:0] base, input int ch);
        at = base + 12'(ch * 4);
    endfunction

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000);
        chk(rdat, exp);
    endtask
    // Flags sampled mid-cycle, one edge on, so registered flags have settled
    task automatic oc(input int i, input logic e);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({31'h0, flags[i]}, {31'h0, e});
    endtask
    task automatic pulse(input int b, input int n);
        src.step(b, 1'b1, n);
        src.step(b, 1'b0, n);
    endtask
    task automatic quad(input int a, input int b);
        src.step(a, 1'b1, QG);
        src.step(b, 1'b1, QG);
        src.step(a, 1'b0, QG);
        src.step(b, 1'b0, QG);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        wrap_up;
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rc(`HSPC_ADDR_QMODE, 32'h3);
        rc(12'hffc, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        // Scan counter and single counter both on input 0
        wr(`HSPC_ADDR_CTRL, 32'h101);
        oc(11, 1'b1);
        rc(`HSPC_ADDR_CTRL, 32'h0);
        wr(`HSPC_ADDR_STATUS, 32'h1);
        oc(11, 1'b0);
        // Scan counter 4: rising, then falling, then counting down
        wr(`HSPC_ADDR_CTRL, 32'h10);
        wr(at(`HSPC_ADDR_PRESET_BASE, 4), 32'h2);
        src.step(4, 1'b1, SG);
        rc(at(CB, 4), 32'h1);
        src.step(4, 1'b0, SG);
        rc(at(CB, 4), 32'h1);
        wr(`HSPC_ADDR_EDGE, 32'h10);
        pulse(4, SG);
        rc(at(CB, 4), 32'h2);
        oc(4, 1'b1);
        wr(`HSPC_ADDR_DIR, 32'h10);
        pulse(4, SG);
        rc(at(CB, 4), 32'h1);
        oc(4, 1'b0);
        wr(`HSPC_ADDR_RESET, 32'h10);
        rc(at(CB, 4), 32'h0);
        // Up/down pair on inputs 0 and 1
        wr(`HSPC_ADDR_CTRL, 32'h200);
        pulse(0, HG);
        pulse(0, HG);
        pulse(1, HG);
        rc(at(CB, 9), 32'h1);
        // Direction-input form: input 1 high makes input 0 count down
        wr(`HSPC_ADDR_BIND, 32'h1);
        src.step(1, 1'b1, HG);
        pulse(0, HG);
        rc(at(CB, 9), 32'h0);
        src.step(1, 1'b0, HG);
        pulse(0, HG);
        rc(at(CB, 9), 32'h1);
        wr(`HSPC_ADDR_BIND, 32'h0);
        // Single counter with its companion reset input
        wr(`HSPC_ADDR_CTRL, 32'h100);
        wr(at(`HSPC_ADDR_PRESET_BASE, 8), 32'h1);
        pulse(0, HG);
        oc(8, 1'b1);
        pulse(0, HG);
        rc(at(CB, 8), 32'h2);
        src.step(1, 1'b1, HG);
        rc(at(CB, 8), 32'h0);
        src.step(1, 1'b0, HG);
        wr(`HSPC_ADDR_RSTDIS, 32'hffffffff);
        pulse(0, HG);
        pulse(1, HG);
        rc(at(CB, 8), 32'h1);
        wr(`HSPC_ADDR_RSTDIS, 32'h0);
        wr(`HSPC_ADDR_IRQEN, 32'hffffffff);
        wr(at(CB, 8), 32'h00010005);
        src.step(1, 1'b1, HG);
        rc(`HSPC_ADDR_CAP_LO, 32'h5);
        rc(`HSPC_ADDR_CAP_HI, 32'h1);
        rc(at(CB, 8), 32'h0);
        chk(irqs, 32'h1);
        // Quadrature: A leading at quadruple rate, B leading at double
        wr(`HSPC_ADDR_CTRL, 32'h400);
        quad(2, 3);
        rc(at(CB, 10), 32'h4);
        wr(`HSPC_ADDR_QMODE, 32'h2);
        quad(3, 2);
        rc(at(CB, 10), 32'h2);
        wrap_up;
    end
endmodule
`default_nettype wire
